// ===== selective_wake_status_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - HV measurement holds both level bits zero.
// - Disabled pin feature freezes its level bit.
// - Switch overcurrent sets overcurrent bit six.
// - Overcurrent flag sticky until host read.
// - Open load sets bit six, high-side only.
// - Reserved bits always read zero.
// - Sync bit after clean frame, else zero.
// - Silence bit while limit exceeded, active only.
// - Active needs no error, valid config, mode.
// - Activation only on mode change, not 100.
// - Wake pattern detection sets bit one.
// - Matching wake frame sets bit zero.
// - Six-bit frame error count in bits 5:0.
// - Valid frame decrements nonzero count, active only.
// - Count 32 disables, errors, enables wake.
// - High register shows average bits 11:4.
// - Low register shows bits 3:0 high nibble.
// - Reset values: A0 high, zeros elsewhere.
module selective_wake_status_regs (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Host serial port pins.
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Wake and auxiliary pin levels, asynchronous.
  input wire logic wake_pin_raw,
  input wire logic aux_pin_raw,
  // Pin feature configuration.
  input wire logic hv_measure_enable,
  input wire logic wake_feature_enable,
  input wire logic aux_feature_enable,
  input wire wake_status_pkg::aux_mode_e aux_mode,
  // Auxiliary switch monitors.
  input wire logic aux_switch_overcurrent,
  input wire logic aux_switch_open_load,
  // Mode control from the control registers.
  input wire logic can_mode_write,
  input wire logic [2:0] can_mode_new,
  input wire logic config_valid_flag,
  input wire logic system_error_clear,
  // Partial wake decoder events.
  input wire logic frame_clean,
  input wire logic frame_valid,
  input wire logic frame_error,
  input wire logic silence_exceeded,
  input wire logic wake_pattern_detect,
  input wire logic wake_frame_detect,
  // Clock recovery filter output.
  input wire logic avg_update,
  input wire logic [wake_status_pkg::AVG_W-1:0] averaged_bit_clocks,
  // Status towards the rest of the device.
  output logic wake_pin_level,
  output logic aux_pin_level,
  output logic partial_wake_active,
  output logic system_error_flag,
  output logic can_wake_capable
);
  import wake_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic wake_pin_s, aux_pin_s;
  logic wake_lvl_q, wake_lvl_d, aux_lvl_q, aux_lvl_d;
  logic oc_q, oc_d, ol_q, ol_d;
  logic oc_event, ol_event;
  logic [2:0] mode_q, mode_d;
  logic active_q, active_d, sys_err_q, sys_err_d, wake_cap_q, wake_cap_d;
  logic start, cfg_error, hit_limit;
  logic [CNT_W-1:0] err_q, err_d;
  logic sync_q, sync_d, sil_q, sil_d, pattern_q, pattern_d, wframe_q, wframe_d;
  logic [AVG_W-1:0] avg_q, avg_d;
  logic [ADDR_W-1:0] rd_addr;
  logic rd_strobe, rd_is_read, rd_clear;
  logic [DATA_W-1:0] rd_data;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame slave.

  // The slave asks for a register in the cycle after the address byte completes.
  spi_frame_slave u_spi (
    .clk(clk),
    .rst(rst),
    .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .rd_addr(rd_addr),
    .rd_strobe(rd_strobe),
    .rd_is_read(rd_is_read),
    .rd_data(rd_data)
  );

  // Only a read clears; a write frame is answered with data but changes nothing.
  assign rd_clear = rd_strobe & rd_is_read;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin levels.

  // The pin levels arrive from outside the clock domain.
  pin_sync_filter #(.WIDTH(2), .INIT(2'b00)) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .raw({wake_pin_raw, aux_pin_raw}),
    .clean({wake_pin_s, aux_pin_s})
  );

  // Measurement mode wins over sampling; a disabled feature keeps its last level.
  always_comb begin
    wake_lvl_d = wake_lvl_q;
    aux_lvl_d = aux_lvl_q;
    if (hv_measure_enable) begin
      wake_lvl_d = 1'b0;
      aux_lvl_d = 1'b0;
    end else begin
      if (wake_feature_enable) begin
        wake_lvl_d = wake_pin_s;
      end
      if (aux_feature_enable) begin
        aux_lvl_d = aux_pin_s;
      end
    end
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_lvl_q <= 1'b0;
      aux_lvl_q <= 1'b0;
    end else begin
      wake_lvl_q <= wake_lvl_d;
      aux_lvl_q <= aux_lvl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Auxiliary switch flags.

  // Overcurrent counts in either switch mode, open load only as a high-side switch.
  assign oc_event = aux_switch_overcurrent
                    & ((aux_mode == AUX_LOW_SIDE) | (aux_mode == AUX_HIGH_SIDE));
  assign ol_event = aux_switch_open_load & (aux_mode == AUX_HIGH_SIDE);

  // The set is applied after the clear, so an event in the read cycle survives.
  always_comb begin
    oc_d = oc_q;
    ol_d = ol_q;
    if (rd_clear && rd_addr == OFS_PIN_OC) begin
      oc_d = 1'b0;
    end
    if (rd_clear && rd_addr == OFS_PIN_OL) begin
      ol_d = 1'b0;
    end
    if (oc_event) begin
      oc_d = 1'b1;
    end
    if (ol_event) begin
      ol_d = 1'b1;
    end
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (rst) begin
      oc_q <= 1'b0;
      ol_q <= 1'b0;
    end else begin
      oc_q <= oc_d;
      ol_q <= ol_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Activation and system error.

  // An overflow is the count stepping from 31 to 32 while active.
  assign hit_limit = active_q & frame_error & ~frame_valid
                     & (err_q == ERR_LIMIT - 6'h01);

  // Activation is only tried on a real mode change into a partial wake mode.
  always_comb begin
    mode_d = mode_q;
    active_d = active_q;
    sys_err_d = sys_err_q;
    wake_cap_d = wake_cap_q;
    start = 1'b0;
    cfg_error = 1'b0;
    if (system_error_clear) begin
      sys_err_d = 1'b0;
    end
    if (can_mode_write) begin
      mode_d = can_mode_new;
      wake_cap_d = 1'b0;
      if (!can_mode_new[CAN_PW_BIT]) begin
        active_d = 1'b0;
      end else if (can_mode_new != mode_q && can_mode_new != CAN_MODE_NO_ACT) begin
        if (!config_valid_flag) begin
          cfg_error = 1'b1;
        end else if (!sys_err_q) begin
          active_d = 1'b1;
          start = 1'b1;
        end
      end
    end
    if (!config_valid_flag) begin
      active_d = 1'b0;
    end
    if (cfg_error) begin
      sys_err_d = 1'b1;
    end
    // Overflow overrides activation, error clear and wake clear in the same cycle; a mode write still stores its code.
    if (hit_limit) begin
      active_d = 1'b0;
      sys_err_d = 1'b1;
      wake_cap_d = 1'b1;
      start = 1'b0;
    end
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= CAN_MODE_RST;
      active_q <= 1'b0;
      sys_err_q <= 1'b0;
      wake_cap_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      active_q <= active_d;
      sys_err_q <= sys_err_d;
      wake_cap_q <= wake_cap_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame error counter.

  // An error and a valid frame in the same cycle cancel out.
  always_comb begin
    err_d = err_q;
    if (start) begin
      err_d = ERR_RST;
    end else if (hit_limit) begin
      err_d = ERR_LIMIT;
    end else if (active_q && err_q != ERR_LIMIT) begin
      if (frame_error && !frame_valid) begin
        err_d = err_q + 6'h01;
      end else if (frame_valid && !frame_error && err_q != ERR_RST) begin
        err_d = err_q - 6'h01;
      end
    end
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (rst) begin
      err_q <= ERR_RST;
    end else begin
      err_q <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Partial wake status flags.

  // Sync and silence only mean something while the function runs.
  always_comb begin
    sync_d = sync_q;
    pattern_d = pattern_q;
    wframe_d = wframe_q;
    sil_d = active_q & silence_exceeded;
    if (!active_q) begin
      sync_d = 1'b0;
    end else if (frame_clean) begin
      sync_d = 1'b1;
    end
    // A fresh activation starts from clean detection flags.
    if (start) begin
      pattern_d = 1'b0;
      wframe_d = 1'b0;
    end
    if (wake_pattern_detect) begin
      pattern_d = 1'b1;
    end
    if (wake_frame_detect) begin
      wframe_d = 1'b1;
    end
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_q <= 1'b0;
      sil_q <= 1'b0;
      pattern_q <= 1'b0;
      wframe_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      sil_q <= sil_d;
      pattern_q <= pattern_d;
      wframe_q <= wframe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Averaged bit length.

  // Capture the filter word whole so the two halves never tear within one update.
  always_comb begin
    avg_d = avg_q;
    if (avg_update) begin
      avg_d = averaged_bit_clocks;
    end
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (rst) begin
      avg_q <= {RST_AVG_HIGH, RST_AVG_LOW[DATA_W-1:4]};
    end else begin
      avg_q <= avg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data.

  // Unmapped offsets and reserved positions read as zero.
  always_comb begin
    rd_data = '0;
    unique case (rd_addr)
      OFS_PIN_OC: begin
        rd_data[OC_BIT] = oc_q;
      end
      OFS_PIN_OL: begin
        rd_data[OL_BIT] = ol_q;
      end
      OFS_PW_STAT: begin
        rd_data[SYNC_BIT] = sync_q;
        rd_data[SIL_BIT] = sil_q;
        rd_data[ACT_BIT] = active_q;
        rd_data[PATTERN_BIT] = pattern_q;
        rd_data[WFRAME_BIT] = wframe_q;
      end
      OFS_PW_ERRCNT: begin
        rd_data[CNT_W-1:0] = err_q;
      end
      OFS_AVG_HIGH: begin
        rd_data = avg_q[AVG_W-1:4];
      end
      OFS_AVG_LOW: begin
        rd_data[DATA_W-1:4] = avg_q[3:0];
      end
      default: begin
        rd_data = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign wake_pin_level = wake_lvl_q;
  assign aux_pin_level = aux_lvl_q;
  assign partial_wake_active = active_q;
  assign system_error_flag = sys_err_q;
  assign can_wake_capable = wake_cap_q;

endmodule

`default_nettype wire

// ===== wake_status_pkg.sv
`default_nettype none

// Shared constants for the partial wake status register bank.
package wake_status_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame layout.
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int RW_BIT = 7;
  localparam logic RW_READ = 1'b0;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] ADDR_BITS = 5'h08;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [ADDR_W-1:0] OFS_PIN_OC = 7'h54;
  localparam logic [ADDR_W-1:0] OFS_PIN_OL = 7'h55;
  localparam logic [ADDR_W-1:0] OFS_PW_STAT = 7'h70;
  localparam logic [ADDR_W-1:0] OFS_PW_ERRCNT = 7'h71;
  localparam logic [ADDR_W-1:0] OFS_AVG_HIGH = 7'h72;
  localparam logic [ADDR_W-1:0] OFS_AVG_LOW = 7'h73;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int OC_BIT = 6;
  localparam int OL_BIT = 6;
  localparam int SYNC_BIT = 6;
  localparam int SIL_BIT = 3;
  localparam int ACT_BIT = 2;
  localparam int PATTERN_BIT = 1;
  localparam int WFRAME_BIT = 0;
  localparam int CAN_PW_BIT = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths, limits and values after reset.
  localparam int CNT_W = 6;
  localparam int AVG_W = 12;
  localparam logic [CNT_W-1:0] ERR_LIMIT = 6'h20;
  localparam logic [CNT_W-1:0] ERR_RST = 6'h00;
  localparam logic [DATA_W-1:0] RST_AVG_HIGH = 8'ha0;
  localparam logic [DATA_W-1:0] RST_AVG_LOW = 8'h00;
  localparam logic [2:0] CAN_MODE_RST = 3'h0;
  localparam logic [2:0] CAN_MODE_NO_ACT = 3'h4;

  // Auxiliary pin configuration codes.
  typedef enum logic [1:0] {
    AUX_OFF = 2'h0,
    AUX_LOW_SIDE = 2'h1,
    AUX_HIGH_SIDE = 2'h2,
    AUX_OTHER = 2'h3
  } aux_mode_e;

endpackage

`default_nettype wire

// ===== pin_sync_filter.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser per bit; output moves only when stages two and three agree.
module pin_sync_filter #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Asynchronous inputs and filtered outputs.
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] clean
);

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic s1_q, s2_q, s3_q, out_q, out_d;

    // Stage one feeds only stage two, so metastability never reaches the comparator.
    always_comb begin
      out_d = out_q;
      if (s2_q == s3_q) begin
        out_d = s3_q;
      end
    end

    // Registers only.
    always_ff @(posedge clk) begin
      if (rst) begin
        s1_q <= INIT[i];
        s2_q <= INIT[i];
        s3_q <= INIT[i];
        out_q <= INIT[i];
      end else begin
        s1_q <= raw[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        out_q <= out_d;
      end
    end

    assign clean[i] = out_q;
  end

endmodule

`default_nettype wire

// ===== spi_frame_slave.sv
`timescale 1ns/1ps
`default_nettype none

// Sixteen-bit serial frame slave: address byte in, read data out in the second byte.
module spi_frame_slave (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Serial pins.
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Register read port.
  output logic [wake_status_pkg::ADDR_W-1:0] rd_addr,
  output logic rd_strobe,
  output logic rd_is_read,
  input wire logic [wake_status_pkg::DATA_W-1:0] rd_data
);
  import wake_status_pkg::*;

  logic cs_n_s, sclk_s, sdi_s;
  logic sclk_prev_q, strobe_q, strobe_d, sdo_q, sdo_d, rise, fall;
  logic [4:0] cnt_q, cnt_d;
  logic [DATA_W-1:0] in_q, in_d, out_q, out_d;

  // Pins come from the host's domain and are filtered before use.
  pin_sync_filter #(.WIDTH(3), .INIT(3'b100)) u_sync (
    .clk(clk),
    .rst(rst),
    .raw({spi_cs_n, spi_sclk, spi_sdi}),
    .clean({cs_n_s, sclk_s, sdi_s})
  );

  assign rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  assign fall = ~sclk_s & sclk_prev_q & ~cs_n_s;

  // Shift in on rising edges, shift out on falling edges, least significant bit first.
  always_comb begin
    cnt_d = cnt_q;
    in_d = in_q;
    out_d = out_q;
    sdo_d = sdo_q;
    strobe_d = 1'b0;
    if (cs_n_s) begin
      cnt_d = '0;
      out_d = '0;
      sdo_d = 1'b0;
    end else begin
      if (rise && cnt_q < FRAME_BITS) begin
        in_d = {sdi_s, in_q[DATA_W-1:1]};
        cnt_d = cnt_q + 5'h01;
        strobe_d = (cnt_q == ADDR_BITS - 5'h01);
      end
      if (strobe_q) begin
        out_d = rd_data;
      end else if (fall && cnt_q >= ADDR_BITS) begin
        sdo_d = out_q[0];
        out_d = {1'b0, out_q[DATA_W-1:1]};
      end
    end
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_prev_q <= 1'b0;
      strobe_q <= 1'b0;
      sdo_q <= 1'b0;
      cnt_q <= '0;
      in_q <= '0;
      out_q <= '0;
    end else begin
      sclk_prev_q <= sclk_s;
      strobe_q <= strobe_d;
      sdo_q <= sdo_d;
      cnt_q <= cnt_d;
      in_q <= in_d;
      out_q <= out_d;
    end
  end

  assign rd_strobe = strobe_q;
  assign rd_addr = in_q[ADDR_W-1:0];
  assign rd_is_read = (in_q[RW_BIT] == RW_READ);
  assign spi_sdo = sdo_q;
  assign spi_sdo_oe = ~cs_n_s;

endmodule

`default_nettype wire

// ===== swk_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// Ties the bank's status outputs to their causes at the inputs.
module partial_wake_asserts (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Watched inputs.
  input wire logic spi_cs_n,
  input wire logic hv_measure_enable,
  input wire logic wake_feature_enable,
  input wire logic can_mode_write,
  input wire logic [2:0] can_mode_new,
  input wire logic config_valid_flag,
  // Watched outputs.
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe,
  input wire logic wake_pin_level,
  input wire logic aux_pin_level,
  input wire logic partial_wake_active,
  input wire logic system_error_flag,
  input wire logic can_wake_capable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////
  // The !$past(rst) terms skip the first edge after reset, where old values still linger.
  property p_meas_zero;
    hv_measure_enable && $past(hv_measure_enable) |-> !wake_pin_level && !aux_pin_level;
  endproperty
  a_meas_zero: assert property (p_meas_zero)
    else $error("level bit set in measurement mode");
  property p_wake_hold;
    !$past(rst) && !wake_feature_enable && !hv_measure_enable
      && $past(!wake_feature_enable && !hv_measure_enable) |-> $stable(wake_pin_level);
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("wake level moved while disabled");
  property p_act_cause;
    $rose(partial_wake_active) |-> $past(can_mode_write && can_mode_new[2]
      && can_mode_new != 3'h4 && config_valid_flag && !system_error_flag);
  endproperty
  a_act_cause: assert property (p_act_cause)
    else $error("activation without a valid mode change");
  property p_cfg_off;
    !config_valid_flag |=> !partial_wake_active;
  endproperty
  a_cfg_off: assert property (p_cfg_off)
    else $error("active with invalid configuration");
  property p_no_100;
    can_mode_write && can_mode_new == 3'h4 && !partial_wake_active |=> !partial_wake_active;
  endproperty
  a_no_100: assert property (p_no_100)
    else $error("mode code 100 activated");
  property p_no_write;
    !can_mode_write && !partial_wake_active |=> !partial_wake_active;
  endproperty
  a_no_write: assert property (p_no_write)
    else $error("activation without a mode write");
  property p_wake_cap;
    $rose(can_wake_capable) |-> system_error_flag && !partial_wake_active;
  endproperty
  a_wake_cap: assert property (p_wake_cap)
    else $error("wake capable without overflow actions");
  property p_overflow;
    !$past(rst) && $fell(partial_wake_active) && !$past(can_mode_write)
      && $past(config_valid_flag) |-> system_error_flag && can_wake_capable;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("deactivation without overflow actions");
  property p_cs_idle;
    spi_cs_n [*8] |-> !spi_sdo_oe && !spi_sdo;
  endproperty
  a_cs_idle: assert property (p_cs_idle)
    else $error("serial output driven while deselected");

  c_act: cover property ($rose(partial_wake_active));
  c_cap: cover property ($rose(can_wake_capable));
  c_frame: cover property ($fell(spi_sdo_oe));
endmodule

bind selective_wake_status_regs partial_wake_asserts i_chk (
  .clk, .rst, .spi_cs_n, .hv_measure_enable, .wake_feature_enable, .can_mode_write,
  .can_mode_new, .config_valid_flag, .spi_sdo, .spi_sdo_oe, .wake_pin_level,
  .aux_pin_level, .partial_wake_active, .system_error_flag, .can_wake_capable
);

`default_nettype wire

// ===== host_spi_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host master: sixteen-bit frames, LSB first, read data in the second byte.
module host_spi_model (
  // Device clock, only paces the pins.
  input wire logic clk,
  // Serial pins.
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe
);
  import wake_status_pkg::*;

  // Idle levels follow the pin pulls: select high, clock and data low.
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
  end

  // Eight device clocks per half period give the 160 ns serial clock.
  task automatic half();
    repeat (8) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////
  // An undriven output reads as unknown, so a lazy enable cannot pass.
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic rw,
                      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
    logic [15:0] word;
    word = {wd, rw, a};
    rd = '0;
    spi_cs_n = 1'b0;
    half();
    for (int i = 0; i < 16; i++) begin
      spi_sdi = word[i];
      half();
      spi_sclk = 1'b1;
      if (i >= 8) begin
        rd[i-8] = spi_sdo_oe ? spi_sdo : 1'bx;
      end
      half();
      spi_sclk = 1'b0;
    end
    spi_sdi = 1'b0;
    half();
    spi_cs_n = 1'b1;
    half();
  endtask
endmodule

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import wake_status_pkg::*;

  // Device pins and events.
  logic clk, rst, wake_pin_raw, aux_pin_raw, hv_measure_enable, wake_feature_enable;
  logic aux_feature_enable, aux_switch_overcurrent, aux_switch_open_load, can_mode_write;
  logic config_valid_flag, system_error_clear, frame_clean, frame_valid, frame_error;
  logic silence_exceeded, wake_pattern_detect, wake_frame_detect, avg_update;
  logic [2:0] can_mode_new;
  logic [AVG_W-1:0] averaged_bit_clocks;
  logic [7:0] junk;
  aux_mode_e aux_mode;
  aux_mode_e sw [2] = '{AUX_LOW_SIDE, AUX_HIGH_SIDE};
  wire spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe, wake_pin_level, aux_pin_level;
  wire partial_wake_active, system_error_flag, can_wake_capable;
  int n_mismatch = 0;
  int num_checks = 0;

  selective_wake_status_regs i_dut (
    .clk, .rst, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo, .spi_sdo_oe, .wake_pin_raw,
    .aux_pin_raw, .hv_measure_enable, .wake_feature_enable, .aux_feature_enable, .aux_mode,
    .aux_switch_overcurrent, .aux_switch_open_load, .can_mode_write, .can_mode_new,
    .config_valid_flag, .system_error_clear, .frame_clean, .frame_valid, .frame_error,
    .silence_exceeded, .wake_pattern_detect, .wake_frame_detect, .avg_update,
    .averaged_bit_clocks, .wake_pin_level, .aux_pin_level, .partial_wake_active,
    .system_error_flag, .can_wake_capable
  );
  host_spi_model i_host (.clk, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo, .spi_sdo_oe);

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////
  // Inputs always move 1 ns after a rising edge, clear of the sampling instant.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.xfer(a, RW_READ, 8'h00, d);
    check(d, exp);
  endtask

  task automatic mode(input logic [2:0] code);
    can_mode_new = code;
    can_mode_write = 1'b1;
    step(1);
    can_mode_write = 1'b0;
    step(1);
  endtask

  // Order: clean, valid, error, pattern, frame; each pulse is followed by an idle cycle.
  task automatic ev(input logic [4:0] e, input int n);
    repeat (n) begin
      {frame_clean, frame_valid, frame_error, wake_pattern_detect, wake_frame_detect} = e;
      step(1);
      {frame_clean, frame_valid, frame_error, wake_pattern_detect, wake_frame_detect} = '0;
      step(1);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The sequence needs about 75 us; 500 us means a hang.
  initial begin
    #500_000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    {wake_pin_raw, aux_pin_raw, hv_measure_enable, wake_feature_enable} = '0;
    {aux_feature_enable, aux_switch_overcurrent, aux_switch_open_load, can_mode_write} = '0;
    {system_error_clear, frame_clean, frame_valid, frame_error, silence_exceeded} = '0;
    {wake_pattern_detect, wake_frame_detect, avg_update} = '0;
    {can_mode_new, averaged_bit_clocks} = '0;
    aux_mode = AUX_OFF;
    config_valid_flag = 1'b1;
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(8);
    rd(OFS_PIN_OC, 8'h00);
    rd(OFS_PIN_OL, 8'h00);
    rd(OFS_PW_STAT, 8'h00);
    rd(OFS_PW_ERRCNT, 8'h00);
    rd(OFS_AVG_HIGH, 8'ha0);
    rd(OFS_AVG_LOW, 8'h00);
    rd(7'h10, 8'h00);
    // Overcurrent counts only in a switch mode and survives the switch going off.
    aux_mode = AUX_OTHER;
    aux_switch_overcurrent = 1'b1;
    step(1);
    aux_switch_overcurrent = 1'b0;
    rd(OFS_PIN_OC, 8'h00);
    foreach (sw[i]) begin
      aux_mode = sw[i];
      aux_switch_overcurrent = 1'b1;
      step(1);
      aux_switch_overcurrent = 1'b0;
      aux_mode = AUX_OFF;
      rd(OFS_PIN_OC, 8'h40);
    end
    rd(OFS_PIN_OC, 8'h00);
    aux_mode = AUX_LOW_SIDE;
    aux_switch_open_load = 1'b1;
    step(2);
    aux_switch_open_load = 1'b0;
    rd(OFS_PIN_OL, 8'h00);
    aux_mode = AUX_HIGH_SIDE;
    aux_switch_open_load = 1'b1;
    step(1);
    aux_switch_open_load = 1'b0;
    aux_mode = AUX_OFF;
    rd(OFS_PIN_OL, 8'h40);
    rd(OFS_PIN_OL, 8'h00);
    // The average is captured only on its strobe; a later change alone is not seen.
    averaged_bit_clocks = 12'ha5c;
    avg_update = 1'b1;
    step(1);
    avg_update = 1'b0;
    averaged_bit_clocks = 12'h3f1;
    rd(OFS_AVG_HIGH, 8'ha5);
    rd(OFS_AVG_LOW, 8'hc0);
    i_host.xfer(OFS_AVG_HIGH, ~RW_READ, 8'hff, junk);
    rd(OFS_AVG_HIGH, 8'ha5);
    // Activation, status flags, then error counting up to the overflow.
    mode(CAN_MODE_NO_ACT);
    check({7'h00, partial_wake_active}, 8'h00);
    mode(3'h6);
    check({7'h00, partial_wake_active}, 8'h01);
    ev(5'h13, 1);
    silence_exceeded = 1'b1;
    step(2);
    rd(OFS_PW_STAT, 8'h4f);
    silence_exceeded = 1'b0;
    step(2);
    rd(OFS_PW_STAT, 8'h47);
    ev(5'h04, 3);
    ev(5'h08, 1);
    rd(OFS_PW_ERRCNT, 8'h02);
    ev(5'h0c, 1);
    ev(5'h08, 3);
    rd(OFS_PW_ERRCNT, 8'h00);
    ev(5'h04, 31);
    rd(OFS_PW_ERRCNT, 8'h1f);
    ev(5'h04, 1);
    check({5'h00, partial_wake_active, system_error_flag, can_wake_capable}, 8'h03);
    ev(5'h08, 1);
    silence_exceeded = 1'b1;
    rd(OFS_PW_ERRCNT, 8'h20);
    rd(OFS_PW_STAT, 8'h03);
    silence_exceeded = 1'b0;
    mode(3'h5);
    check({5'h00, partial_wake_active, system_error_flag, can_wake_capable}, 8'h02);
    system_error_clear = 1'b1;
    step(1);
    system_error_clear = 1'b0;
    mode(3'h7);
    check({5'h00, partial_wake_active, system_error_flag, can_wake_capable}, 8'h04);
    rd(OFS_PW_STAT, 8'h04);
    config_valid_flag = 1'b0;
    step(2);
    check({7'h00, partial_wake_active}, 8'h00);
    config_valid_flag = 1'b1;
    // Rewriting the stored mode is no mode change, so nothing starts.
    mode(3'h7);
    check({7'h00, partial_wake_active}, 8'h00);
    // Pin levels follow, drop in measurement mode, and freeze while disabled.
    {wake_feature_enable, aux_feature_enable, wake_pin_raw, aux_pin_raw} = 4'hf;
    step(12);
    check({6'h00, wake_pin_level, aux_pin_level}, 8'h03);
    hv_measure_enable = 1'b1;
    step(2);
    check({6'h00, wake_pin_level, aux_pin_level}, 8'h00);
    hv_measure_enable = 1'b0;
    step(12);
    {wake_feature_enable, aux_feature_enable, wake_pin_raw, aux_pin_raw} = 4'h0;
    step(12);
    check({6'h00, wake_pin_level, aux_pin_level}, 8'h03);
    print_verdict();
  end
endmodule

`default_nettype wire
